// >>> vram_wait_precharge_transfer_ctrl.sv
// Purpose: wait extension, per-bank precharge, refresh low time and
//          shift-register transfer sequencing of a video ram controller
// Assumes: all inputs synchronous to hclk; hclk locked to the shift clock
// Notes:   configuration is loaded by an ahb write to the cfg register

module vram_wait_precharge_transfer_ctrl #(
    parameter int NUM_BANKS = 4
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  vram_ctrl_pkg::ahb_req_t        ahb_req,
    output vram_ctrl_pkg::ahb_rsp_t        ahb_rsp,
    input  wire logic                      address_strobe_n,
    input  wire logic                      access_request_n,
    input  wire logic [1:0]                bank_sel,
    input  wire logic                      wait_extend_in,
    input  wire logic                      page_restart,
    input  wire logic                      refresh_request,
    input  wire logic                      second_port_request,
    input  wire logic                      transfer_advance_request,
    input  wire logic                      transfer_start_strobe,
    input  wire logic                      column_extend_in_0,
    output logic [NUM_BANKS-1:0]           ras_n,
    output logic                           data_ack_out_n,
    output logic                           transfer_output_enable,
    output logic                           port_a_busy,
    output logic                           second_port_grant
);
    import vram_ctrl_pkg::*;

    if (NUM_BANKS < 1 || NUM_BANKS > 4) begin : g_chk
        $error("NUM_BANKS must be 1 to 4");
    end

    // packed msb first, so the field order mirrors the register layout
    typedef struct packed {
        logic                 col_extend_cfg;
        logic                 half_cycle;
        logic [1:0]           base_edges;
        logic                 ack_style_select_bit;
        logic                 extra_edge_select_bit;
        logic                 precharge_select_bit_hi;
        logic                 precharge_select_bit_lo;
    } cfg_t;

    typedef struct packed {
        cfg_t                 cfg;
        logic                 dp_valid;
        logic                 dp_write;
        logic [7:0]           dp_addr;
        logic [31:0]          rdata;
        cyc_state_t           state;
        logic [1:0]           bank;
        logic [NUM_BANKS-1:0] ras_n;
        logic [3:0]           wait_cnt;
        logic                 extend_seen;
        logic [2:0]           rlow_cnt;
        logic                 adv_busy;
        logic                 xfer_seen;
        logic [2:0]           xfer_cnt;
        logic                 grant_b;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic [NUM_BANKS-1:0] prech_start;
    logic [NUM_BANKS-1:0] prech_ready;
    logic [2:0]           prech_target;
    logic [2:0]           rlow_target;
    logic [3:0]           wait_target;
    logic                 pos_done;
    logic                 half_done;
    logic                 wait_done;
    logic                 xfer_en;
    logic                 xfer_cycle;
    logic                 waiting;
    logic                 cycle_active;
    logic                 take;
    logic                 access_req;
    logic                 ref_req;
    logic [7:0]           status_val;

    // precharge and refresh low figures from the two select bits
    always_comb begin
        case ({s_reg.cfg.precharge_select_bit_hi, s_reg.cfg.precharge_select_bit_lo})
            2'h0: begin
                prech_target = PRECH_EDGES_0;
                rlow_target  = RLOW_EDGES_0;
            end
            2'h1: begin
                prech_target = PRECH_EDGES_1;
                rlow_target  = RLOW_EDGES_1;
            end
            2'h2: begin
                prech_target = PRECH_EDGES_2;
                rlow_target  = RLOW_EDGES_2;
            end
            default: begin
                prech_target = PRECH_EDGES_3;
                rlow_target  = RLOW_EDGES_3;
            end
        endcase
    end

    // one counter per row strobe, so interleaved banks never wait on each other
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        prech_counter #(
            .W (3)
        ) u_prech (
            .hclk    (hclk),
            .hresetn (hresetn),
            .start   (prech_start[b]),
            .target  (prech_target),
            .ready   (prech_ready[b])
        );
    end

    // wait target: programmed edges plus extension edges while extended
    always_comb begin
        wait_target = {2'h0, s_reg.cfg.base_edges};
        if (s_reg.extend_seen || wait_extend_in) begin
            wait_target = wait_target + (s_reg.cfg.extra_edge_select_bit ?
                          EXTRA_TWO : EXTRA_ONE);
        end
    end

    assign pos_done = (s_reg.state == ST_ACCESS) && (s_reg.wait_cnt >= wait_target);

    // half-cycle term lands on the falling edge after the positive edges
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_done <= 1'b0;
        end else begin
            half_done <= pos_done;
        end
    end

    assign wait_done = pos_done && (!s_reg.cfg.half_cycle || half_done);

    // transfer enable is combinational so the strobe acts at once
    assign xfer_en = transfer_start_strobe &&
                     (!s_reg.cfg.col_extend_cfg || s_reg.xfer_cnt < XFER_EDGES);
    // no shift clock input: transfers behave alike with it running or idle
    assign xfer_cycle = transfer_start_strobe || s_reg.xfer_seen;

    assign access_req = !address_strobe_n && !access_request_n;
    assign ref_req    = refresh_request && !s_reg.adv_busy;

    // ras may only start for a bank whose own counter has run out
    assign take = (s_reg.state == ST_IDLE) && access_req && !s_reg.grant_b &&
                  prech_ready[bank_sel[$clog2(NUM_BANKS > 1 ? NUM_BANKS : 2)-1:0]];

    assign port_a_busy = s_reg.adv_busy || (s_reg.state == ST_ACCESS) ||
                         (!address_strobe_n && !s_reg.grant_b);

    // main sequencing of accesses, refreshes and transfers
    always_comb begin
        s_next      = s_reg;
        prech_start = '0;

        // ahb address phase capture
        if (ahb_req.hready) begin
            s_next.dp_valid = ahb_req.hsel && (ahb_req.htrans == HTRANS_NONSEQ ||
                              ahb_req.htrans == HTRANS_SEQ);
            s_next.dp_write = ahb_req.hwrite;
            s_next.dp_addr  = ahb_req.haddr[ADDR_MSB:ADDR_LSB];
        end
        // write data phase is the programming sequence
        if (s_reg.dp_valid && s_reg.dp_write && s_reg.dp_addr == CFG_OFFSET) begin
            s_next.cfg.precharge_select_bit_lo = ahb_req.hwdata[CFG_PRECH_LO];
            s_next.cfg.precharge_select_bit_hi = ahb_req.hwdata[CFG_PRECH_HI];
            s_next.cfg.extra_edge_select_bit   = ahb_req.hwdata[CFG_EXTRA_SEL];
            s_next.cfg.ack_style_select_bit    = ahb_req.hwdata[CFG_ACK_STYLE];
            s_next.cfg.base_edges = ahb_req.hwdata[CFG_BASE_MSB:CFG_BASE_LSB];
            s_next.cfg.half_cycle              = ahb_req.hwdata[CFG_HALF];
            s_next.cfg.col_extend_cfg          = column_extend_in_0;
        end
        // read data prepared in the address phase, registered for the data phase
        s_next.rdata = '0;
        if (ahb_req.hready && ahb_req.hsel && !ahb_req.hwrite) begin
            if (ahb_req.haddr[ADDR_MSB:ADDR_LSB] == CFG_OFFSET) begin
                s_next.rdata[7:0] = s_reg.cfg;
            end else if (ahb_req.haddr[ADDR_MSB:ADDR_LSB] == STATUS_OFFSET) begin
                s_next.rdata[7:0]  = status_val;
                s_next.rdata[11:8] = 4'(prech_ready);
            end
        end

        // advance request holds the port until the shift load ends
        if (transfer_advance_request) begin
            s_next.adv_busy = 1'b1;
        end else if (s_reg.xfer_seen && !transfer_start_strobe) begin
            s_next.adv_busy = 1'b0;
        end
        s_next.xfer_seen = transfer_start_strobe;
        if (!transfer_start_strobe) begin
            s_next.xfer_cnt = '0;
        end else if (s_reg.xfer_cnt < XFER_EDGES) begin
            s_next.xfer_cnt = s_reg.xfer_cnt + 3'h1;
        end

        // second port served only when idle with no advance hold or port a request; a refresh starting on the same edge is not held off
        s_next.grant_b = second_port_request && !s_reg.adv_busy &&
                         s_reg.state == ST_IDLE && !access_req;

        case (s_reg.state)
            ST_IDLE: begin
                if (take) begin
                    s_next.state       = ST_ACCESS;
                    s_next.bank        = bank_sel;
                    s_next.ras_n[bank_sel] = 1'b0;
                    s_next.wait_cnt    = '0;
                    s_next.extend_seen = wait_extend_in;
                end else if (ref_req && !access_req && !s_reg.grant_b &&
                             &prech_ready) begin
                    s_next.state    = ST_REFRESH;
                    s_next.ras_n    = '0;
                    s_next.rlow_cnt = '0;
                end
            end
            ST_ACCESS: begin
                if (access_request_n) begin
                    s_next.state = ST_IDLE;
                    s_next.ras_n = '1;
                    prech_start[s_reg.bank] = 1'b1;
                end else if (page_restart) begin
                    s_next.wait_cnt    = '0;
                    s_next.extend_seen = wait_extend_in;
                end else begin
                    if (s_reg.wait_cnt < wait_target) begin
                        s_next.wait_cnt = s_reg.wait_cnt + 4'h1;
                    end
                    s_next.extend_seen = s_reg.extend_seen || wait_extend_in;
                end
            end
            ST_REFRESH: begin
                s_next.rlow_cnt = s_reg.rlow_cnt + 3'h1;
                if (s_next.rlow_cnt >= rlow_target) begin
                    s_next.state = ST_IDLE;
                    s_next.ras_n = '1;
                    prech_start  = '1;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
                s_next.ras_n = '1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg          <= '0;
            s_reg.cfg      <= CFG_RESET;
            s_reg.state    <= ST_IDLE;
            s_reg.ras_n    <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // status: state bits, transfer and busy flags
    assign status_val = {s_reg.state, s_reg.adv_busy, xfer_en,
                         s_reg.grant_b, s_reg.bank};

    // waiting: counting wait edges, blocked start, or transfer in progress
    always_comb begin
        if (xfer_cycle) begin
            waiting      = xfer_en;
            cycle_active = transfer_start_strobe || s_reg.state == ST_ACCESS;
        end else begin
            waiting      = (s_reg.state == ST_ACCESS && !wait_done) ||
                           (s_reg.state != ST_ACCESS && !address_strobe_n);
            cycle_active = s_reg.state == ST_ACCESS || !address_strobe_n;
        end
    end

    // wait style is low while waiting; ack style is low once done
    assign data_ack_out_n = s_reg.cfg.ack_style_select_bit ?
                            !(cycle_active && !waiting) : !waiting;

    // with column extend off this is simply the strobe level
    assign transfer_output_enable = xfer_en;
    assign ras_n             = s_reg.ras_n;
    assign second_port_grant = s_reg.grant_b;

    assign ahb_rsp.hrdata    = s_reg.rdata;
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = HRESP_OKAY;
endmodule

// >>> vram_ctrl_pkg.sv
// Purpose: shared constants and types for the vram wait/precharge/transfer block
// Assumes: single 100 MHz clock, ahb-lite register access
// Notes:   edge counts are clock edges of hclk
package vram_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] CFG_OFFSET    = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int         ADDR_LSB      = 0;
    localparam int         ADDR_MSB      = 7;

    // configuration field positions
    localparam int CFG_PRECH_LO  = 0;
    localparam int CFG_PRECH_HI  = 1;
    localparam int CFG_EXTRA_SEL = 2;
    localparam int CFG_ACK_STYLE = 3;
    localparam int CFG_BASE_LSB  = 4;
    localparam int CFG_BASE_MSB  = 5;
    localparam int CFG_HALF      = 6;
    localparam int CFG_COL_EXT   = 7;

    localparam logic [7:0] CFG_RESET = 8'h10;

    // precharge / refresh low edge counts per select code
    localparam logic [2:0] PRECH_EDGES_0 = 3'h2;
    localparam logic [2:0] PRECH_EDGES_1 = 3'h3;
    localparam logic [2:0] PRECH_EDGES_2 = 3'h3;
    localparam logic [2:0] PRECH_EDGES_3 = 3'h4;
    localparam logic [2:0] RLOW_EDGES_0  = 3'h2;
    localparam logic [2:0] RLOW_EDGES_1  = 3'h2;
    localparam logic [2:0] RLOW_EDGES_2  = 3'h3;
    localparam logic [2:0] RLOW_EDGES_3  = 3'h4;

    // extension edges chosen by the extra edge bit
    localparam logic [3:0] EXTRA_ONE = 4'h1;
    localparam logic [3:0] EXTRA_TWO = 4'h2;

    // transfer enable cut-off in rising edges after strobe assertion
    localparam logic [2:0] XFER_EDGES = 3'h4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ahb_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_ACCESS  = 3'b010,
        ST_REFRESH = 3'b100
    } cyc_state_t;

endpackage

// >>> prech_counter.sv
// Purpose: one positive-edge precharge counter for one row strobe
// Assumes: start pulses on the edge that sees the row strobe end
// Notes:   resets to ready so the first access is never held
module prech_counter #(
    parameter int W = 3
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         start,
    input  wire logic [W-1:0] target,
    output logic              ready
);
    import vram_ctrl_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } pc_state_t;

    pc_state_t s_reg;
    pc_state_t s_next;

    // the start edge itself is the first counted edge
    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.cnt = W'(1);
        end else if (s_reg.cnt < target) begin
            s_next.cnt = s_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ready = (s_reg.cnt >= target) && !start;
endmodule

// >>> vram_ctrl_checker.sv
// Purpose: concurrent checks on the wait, precharge and transfer block
// Assumes: cfg is shadowed from ahb writes to the cfg offset
// Notes:   attached to every instance by the bind at the foot
module vram_ctrl_checker #(
    parameter int NUM_BANKS = 4
) (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input vram_ctrl_pkg::ahb_req_t   ahb_req,
    input wire logic                 transfer_advance_request,
    input wire logic                 transfer_start_strobe,
    input wire logic                 column_extend_in_0,
    input wire logic [NUM_BANKS-1:0] ras_n,
    input wire logic                 data_ack_out_n,
    input wire logic                 transfer_output_enable,
    input wire logic                 port_a_busy,
    input wire logic                 second_port_grant
);
    import vram_ctrl_pkg::*;
    logic       wr_q;
    logic [7:0] cfg_q;
    logic [2:0] xfer_cnt;
    logic [2:0] prech_edges;

    // shadow cfg; the column extend level is taken with the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q     <= 1'b0;
            cfg_q    <= CFG_RESET;
            xfer_cnt <= 3'h0;
        end else begin
            wr_q <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite
                && ahb_req.haddr[7:0] == CFG_OFFSET;
            if (wr_q) cfg_q <= {column_extend_in_0, ahb_req.hwdata[6:0]};
            // saturates so a long strobe never wraps back into the window
            xfer_cnt <= !transfer_start_strobe ? 3'h0
                : (xfer_cnt == XFER_EDGES ? XFER_EDGES : xfer_cnt + 3'h1);
        end
    end
    assign prech_edges = cfg_q[1] ? (cfg_q[0] ? PRECH_EDGES_3 : PRECH_EDGES_2)
                                  : (cfg_q[0] ? PRECH_EDGES_1 : PRECH_EDGES_0);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // high-sample run per row strobe, starting full so the first access is free
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic [2:0] hi;
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) hi <= 3'h7;
            else if (!ras_n[b]) hi <= 3'h0;
            else if (hi != 3'h7) hi <= hi + 3'h1;
        end
        prech_gap_a: assert property ($fell(ras_n[b]) |-> hi >= prech_edges)
            else $error("row strobe back before precharge ended");
    end

    xfer_rise_a: assert property ($rose(transfer_start_strobe) |-> transfer_output_enable)
        else $error("transfer enable missed the strobe");
    xfer_track_a: assert property (!cfg_q[7] && transfer_start_strobe |-> transfer_output_enable)
        else $error("transfer enable dropped while tracking");
    xfer_hold_a: assert property (cfg_q[7] && transfer_start_strobe && xfer_cnt < XFER_EDGES
        |-> transfer_output_enable) else $error("transfer enable cut early");
    xfer_cut_a: assert property (cfg_q[7] && transfer_start_strobe && xfer_cnt == XFER_EDGES
        |-> !transfer_output_enable) else $error("transfer enable not cut");
    wait_follow_a: assert property (transfer_start_strobe
        |-> data_ack_out_n == (cfg_q[3] ? transfer_output_enable : !transfer_output_enable))
        else $error("wait output off the transfer enable");
    busy_set_a: assert property ($rose(transfer_advance_request) |=> port_a_busy)
        else $error("advance request did not mark busy");
    grant_block_a: assert property (port_a_busy |=> !$rose(second_port_grant))
        else $error("second port granted while busy");
endmodule

bind vram_wait_precharge_transfer_ctrl vram_ctrl_checker #(.NUM_BANKS(NUM_BANKS)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ras_n(ras_n),
    .transfer_advance_request(transfer_advance_request), .port_a_busy(port_a_busy),
    .transfer_start_strobe(transfer_start_strobe), .column_extend_in_0(column_extend_in_0),
    .data_ack_out_n(data_ack_out_n), .transfer_output_enable(transfer_output_enable),
    .second_port_grant(second_port_grant)
);

// >>> port_a_model.sv
// Purpose: behavioural port a initiator driving the access strobes
// Assumes: done level is high for wait style, low for ack style
// Notes:   polls the wait/ack output every half clock
module port_a_model (
    input  wire logic hclk,
    input  wire logic data_ack_out_n,
    output logic      address_strobe_n,
    output logic      access_request_n,
    output logic [1:0] bank_sel,
    output logic      wait_extend_in,
    output logic      page_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        address_strobe_n = 1'b1;
        access_request_n = 1'b1;
        bank_sel = 2'h0;
        wait_extend_in = 1'b0;
        page_restart = 1'b0;
    end

    // polls from the third step: the output may idle at done before the take
    task automatic settle(input logic style, output int h);
        h = 0;
        do begin
            @(hclk);
            #1;
            h++;
        end while ((h < 3 || data_ack_out_n !== !style) && h < 100);
    endtask

    // strobes stay low until stop, stretched by the inserted waits
    task automatic go(input logic [1:0] bank, input logic ext, input logic style, output int h);
        @(posedge hclk);
        address_strobe_n <= 1'b0;
        access_request_n <= 1'b0;
        bank_sel <= bank;
        wait_extend_in <= ext;
        settle(style, h);
    endtask

    task automatic stop();
        @(posedge hclk);
        address_strobe_n <= 1'b1;
        access_request_n <= 1'b1;
        wait_extend_in <= 1'b0;
    endtask

    // counts from the edge that samples the pulse
    task automatic page(input logic style, output int h);
        @(posedge hclk);
        page_restart <= 1'b1;
        @(posedge hclk);
        page_restart <= 1'b0;
        settle(style, h);
    endtask
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the wait, precharge and transfer block
// Assumes: one 100 MHz clock, cfg written over ahb-lite
// Notes:   waits are measured in half clocks from the request
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vram_ctrl_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic       ext;
        logic [7:0] halves;
    } row_t;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0]  htrans = 2'h0, bank_sel;
    logic        refresh_request = 1'b0, second_port_request = 1'b0;
    logic        transfer_advance_request = 1'b0, transfer_start_strobe = 1'b0;
    logic        column_extend_in_0 = 1'b0, address_strobe_n, access_request_n;
    logic        wait_extend_in, page_restart, data_ack_out_n, transfer_output_enable;
    logic        port_a_busy, second_port_grant;
    logic [3:0]  ras_n;
    ahb_req_t    ahb_req;
    ahb_rsp_t    ahb_rsp;
    int          err_total = 0, cmp_count = 0, cyc = 0, h;
    // half clocks to done across style, extension and half-cycle settings
    row_t rows [6] = '{'{8'h10, 1'b0, 8'h04}, '{8'h10, 1'b1, 8'h06}, '{8'h14, 1'b1, 8'h08},
                       '{8'h58, 1'b0, 8'h05}, '{8'h5C, 1'b1, 8'h09}, '{8'h28, 1'b1, 8'h08}};

    always #5 hclk = ~hclk;
    assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_rsp.hreadyout};

    vram_wait_precharge_transfer_ctrl #(.NUM_BANKS(4)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
        .address_strobe_n(address_strobe_n), .access_request_n(access_request_n),
        .bank_sel(bank_sel), .wait_extend_in(wait_extend_in), .page_restart(page_restart),
        .refresh_request(refresh_request), .second_port_request(second_port_request),
        .transfer_advance_request(transfer_advance_request), .ras_n(ras_n),
        .transfer_start_strobe(transfer_start_strobe), .column_extend_in_0(column_extend_in_0),
        .data_ack_out_n(data_ack_out_n), .transfer_output_enable(transfer_output_enable),
        .port_a_busy(port_a_busy), .second_port_grant(second_port_grant)
    );
    port_a_model i_cpu (
        .hclk(hclk), .data_ack_out_n(data_ack_out_n), .address_strobe_n(address_strobe_n),
        .access_request_n(access_request_n), .bank_sel(bank_sel),
        .wait_extend_in(wait_extend_in), .page_restart(page_restart)
    );

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // single word; each phase held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        r = ahb_rsp.hrdata;
    endtask

    // hang guard, far above the fewer than two hundred cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, CFG_OFFSET, 32'h0, q);
        chk("cfg reset", q, {24'h0, CFG_RESET});
        bus(1'b0, 8'h08, 32'h0, q);
        chk("unmapped read", q, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, CFG_OFFSET, {24'h0, rows[i].cfg}, q);
            i_cpu.go(2'(i), rows[i].ext, rows[i].cfg[3], h);
            chk("wait halves", 32'(h), 32'(rows[i].halves));
            i_cpu.stop();
        end
        // same bank sits out four precharge edges, another bank goes at once
        bus(1'b1, CFG_OFFSET, 32'h0000_001B, q);
        i_cpu.go(2'h3, 1'b0, 1'b1, h);
        i_cpu.stop();
        i_cpu.go(2'h3, 1'b0, 1'b1, h);
        chk("same bank", 32'(h), 32'h0000_000A);
        i_cpu.stop();
        i_cpu.go(2'h2, 1'b1, 1'b1, h);
        chk("other bank", 32'(h), 32'h0000_0006);
        i_cpu.page(1'b1, h);
        chk("page restart", 32'(h), 32'h0000_0004);
        i_cpu.stop();
        // refresh low time, then an access measured against its precharge
        @(posedge hclk) refresh_request <= 1'b1;
        for (int t = 0; t < 50 && ras_n !== 4'h0; t++) begin
            @(posedge hclk);
            #1;
        end
        h = 0;
        while (ras_n === 4'h0 && h < 20) begin
            h++;
            @(posedge hclk);
            #1;
        end
        @(posedge hclk) refresh_request <= 1'b0;
        chk("refresh low", 32'(h), 32'h0000_0004);
        i_cpu.go(2'h0, 1'b0, 1'b1, h);
        chk("after refresh", 32'(h), 32'h0000_0006);
        i_cpu.stop();
        // advance request first, so refresh and the second port are held off
        @(posedge hclk) transfer_advance_request <= 1'b1;
        @(posedge hclk) begin
            refresh_request <= 1'b1;
            second_port_request <= 1'b1;
        end
        repeat (8) @(posedge hclk);
        #1;
        chk("busy", {ras_n, port_a_busy, second_port_grant}, 32'h0000_003E);
        for (int m = 0; m < 2; m++) begin
            @(posedge hclk) column_extend_in_0 <= m[0];
            bus(1'b1, CFG_OFFSET, 32'h0000_0013, q);
            @(posedge hclk) begin
                transfer_start_strobe <= 1'b1;
                transfer_advance_request <= 1'b0;
            end
            #1;
            chk("enable at strobe", 32'(transfer_output_enable), 32'h1);
            repeat (4) @(posedge hclk);
            #1;
            chk("enable after four", 32'(transfer_output_enable), 32'(!m[0]));
            @(posedge hclk) transfer_start_strobe <= 1'b0;
            #1;
            chk("enable at end", 32'(transfer_output_enable), 32'h0);
        end
        bus(1'b0, CFG_OFFSET, 32'h0, q);
        chk("cfg read", q, 32'h0000_0093);
        @(posedge hclk) column_extend_in_0 <= 1'b0;
        bus(1'b0, CFG_OFFSET, 32'h0, q);
        chk("cfg held", q, 32'h0000_0093);
        @(posedge hclk) begin
            refresh_request <= 1'b0;
            second_port_request <= 1'b0;
        end
        summarize();
    end
endmodule
